// file: rtl/flash_led_mode_control.sv
`timescale 1ns/100ps
`include "flash_ctrl_consts.svh"
// Notes on behaviour
// - Ramp monitor enabled and supply dips during ramp: set fault flag bit 6.
// - Ramp-limited flash current holds until host reads the fault flags.
// - Enable bits 4 and 3 switch the two current sources separately.
// - Config1 bit 7 set: multi-function input high turns on torch current.
// - Flash from trigger pin or register overrides hardware torch.
// - Hardware torch: flash end clears config1 bit 7; host sets it again.
// - Flash duration bits 6:5 pick one of four switch current limits.
// - Current limit hit: switching stops until the next switching cycle.
// - Flash duration bits 4:0 give timeout of 32 ms times code plus one.
// - Config1 bit 4 clear: indicator pin is the indicator current source.
// - Enable bit 6 switches the indicator current source.
// - Enable bit 7 selects blinking from the two pattern registers.
// - Blank time is active time times the 16-step blank count.
// - Pulse hold time is 0 to 480 ms in 32 ms steps.
// - Indicator level field picks eight levels, 2.25 mA to 18 mA.
// - Period is two ramps plus two holds; eight period counts.
// - One ramp setting, 78 to 624 ms, serves rise and fall.
// - Supply monitor bit 0 enables; bits 2:1 choose the threshold.
// - Config2 bit 3 picks torch level or off on undervoltage.
// - Current restores only after supply recovers and flags are read.
// - Undervoltage must last 250 us before acting and flagging.
// - Reading the flags clears them; a one means the event happened.
// - Flash timeout turns the sources off whatever the input pin does.
module flash_led_mode_control
    import flash_ctrl_pkg::*;
#(
    parameter int P_CYC_PER_MS = `CYC_PER_MS,
    parameter int P_CYC_UV     = `CYC_UV_DEGLITCH
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_flash_trigger,
    input  wire logic        i_multi_function_input,
    input  wire logic        i_supply_low,
    input  wire logic        i_ramp_supply_low,
    input  wire logic        i_flash_ramping,
    input  wire logic        i_limit_hit,
    input  wire logic        i_switch_cycle,
    input  wire logic        i_overvoltage,
    output logic             o_first_current_source,
    output logic             o_second_current_source,
    output drive_level_t     o_drive_level,
    output logic             o_ramp_halt,
    output logic [1:0]       o_limit_sel,
    output logic             o_switch_enable,
    output logic [1:0]       o_supply_monitor_threshold,
    output logic [1:0]       o_ramp_monitor_threshold,
    output logic             o_indicator_on,
    output logic [2:0]       o_indicator_current_level,
    output ind_phase_t       o_indicator_phase
);
    // ==========================================
    // Elaboration checks
    if (P_CYC_PER_MS < 1 || P_CYC_PER_MS > 65535) begin : g_bad_ms
        $error("P_CYC_PER_MS out of range");
    end
    if (P_CYC_UV < 1 || P_CYC_UV > 65535) begin : g_bad_uv
        $error("P_CYC_UV out of range");
    end

    localparam int NPIN = 8;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_reg;
    logic [NPIN-1:0] sync2_reg;
    logic trig_s, mfi_s, uv_s, rlow_s, ramping_s, limit_s, cycle_s, ovp_s;
    logic        ack_reg;
    logic        acc;
    logic        wr_en;
    logic        rd_flags;
    logic [3:0]  wr_idx;
    logic [7:0]  rdata_reg;
    logic [7:0]  enable_reg, cfg1_reg, cfg2_reg, dur_reg;
    logic [7:0]  ind_reg, blink_reg, mon_reg, flags_reg;
    logic [15:0] ms_cnt_reg;
    logic        ms_tick;
    logic        flash_req, flash_req_d_reg, flash_start, flash_on_reg;
    logic        hwt_flash_reg, timeout, flash_end;
    logic [10:0] to_ms_reg, to_limit;
    logic [15:0] uv_cnt_reg;
    logic        uv_low, uv_trip, uv_act_reg, uv_seen_reg;
    logic        ramp_trip, ramp_hold_reg, ilim_blk_reg;
    logic        ind_run, blink_lit;
    sw_mode_t    sw_mode;
    drive_level_t level_next;
    ind_phase_t   phase_w;

    // ==========================================
    // Pin synchronisers
    assign pin_raw = {i_overvoltage, i_switch_cycle, i_limit_hit, i_flash_ramping,
                      i_ramp_supply_low, i_supply_low, i_multi_function_input,
                      i_flash_trigger};
    for (genvar g = 0; g < NPIN; g++) begin : g_sync
        always_ff @(posedge i_sys_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                sync1_reg[g] <= 1'h0;
                sync2_reg[g] <= 1'h0;
            end else begin
                sync1_reg[g] <= pin_raw[g];
                sync2_reg[g] <= sync1_reg[g];
            end
        end
    end
    assign {ovp_s, cycle_s, limit_s, ramping_s, rlow_s, uv_s, mfi_s, trig_s} = sync2_reg;

    // ==========================================
    // Avalon slave: one wait state per access
    function automatic logic [3:0] reg_index(input logic [4:0] a);
        if (a == `OFS_ENABLE)          reg_index = 4'h0;
        else if (a == `OFS_CFG1)       reg_index = 4'h1;
        else if (a == `OFS_CFG2)       reg_index = 4'h2;
        else if (a == `OFS_FLASH_DUR)  reg_index = 4'h3;
        else if (a == `OFS_INDICATOR)  reg_index = 4'h4;
        else if (a == `OFS_BLINK)      reg_index = 4'h5;
        else if (a == `OFS_SUPPLY_MON) reg_index = 4'h6;
        else if (a == `OFS_FLAGS)      reg_index = 4'h7;
        else                           reg_index = 4'hF;
    endfunction

    assign acc               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = acc & ~ack_reg;
    assign wr_en             = i_avs_write & ack_reg & i_avs_byteenable[0];
    assign wr_idx            = wr_en ? reg_index(i_avs_address) : 4'hF;
    assign rd_flags          = i_avs_read & ack_reg & (reg_index(i_avs_address) == 4'h7);
    assign o_avs_readdata    = {24'h000000, rdata_reg};

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_reg   <= 1'h0;
            rdata_reg <= 8'h00;
        end else begin
            ack_reg <= acc & ~ack_reg;
            if (i_avs_read && !ack_reg) begin
                case (reg_index(i_avs_address))
                    4'h0:    rdata_reg <= enable_reg;
                    4'h1:    rdata_reg <= cfg1_reg;
                    4'h2:    rdata_reg <= cfg2_reg;
                    4'h3:    rdata_reg <= dur_reg;
                    4'h4:    rdata_reg <= ind_reg;
                    4'h5:    rdata_reg <= blink_reg;
                    4'h6:    rdata_reg <= mon_reg;
                    4'h7:    rdata_reg <= flags_reg;
                    default: rdata_reg <= 8'h00;
                endcase
            end
        end
    end

    // ==========================================
    // Configuration registers
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg2_reg  <= `RST_CFG;
            dur_reg   <= `RST_FLASH_DUR;
            ind_reg   <= `RST_CFG;
            blink_reg <= `RST_CFG;
            mon_reg   <= `RST_CFG;
        end else begin
            if (wr_idx == 4'h2) cfg2_reg  <= i_avs_writedata[7:0];
            if (wr_idx == 4'h3) dur_reg   <= i_avs_writedata[7:0];
            if (wr_idx == 4'h4) ind_reg   <= i_avs_writedata[7:0];
            if (wr_idx == 4'h5) blink_reg <= i_avs_writedata[7:0];
            if (wr_idx == 4'h6) mon_reg   <= i_avs_writedata[7:0];
        end
    end

    // Enable and config1 are also altered by the flash sequencer
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            enable_reg <= `RST_ENABLE;
            cfg1_reg   <= `RST_CFG;
        end else begin
            if (wr_idx == 4'h0) begin
                enable_reg <= i_avs_writedata[7:0];
            end else if (timeout && sw_mode == MODE_FLASH) begin
                enable_reg[`EN_MODE_LSB +: 2] <= 2'h0;
            end
            if (wr_idx == 4'h1) begin
                cfg1_reg <= i_avs_writedata[7:0];
            end else if (flash_end && hwt_flash_reg) begin
                cfg1_reg[`CFG1_HWT_BIT] <= 1'h0;
            end
        end
    end
    assign sw_mode = sw_mode_t'(enable_reg[`EN_MODE_LSB +: 2]);

    // ==========================================
    // Millisecond timebase
    assign ms_tick = (ms_cnt_reg == 16'(P_CYC_PER_MS - 1));
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ms_cnt_reg <= 16'h0000;
        end else begin
            ms_cnt_reg <= ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
        end
    end

    // ==========================================
    // Flash sequencer and timeout
    assign flash_req   = trig_s | (sw_mode == MODE_FLASH);
    assign flash_start = flash_req & ~flash_req_d_reg;
    assign to_limit    = ({6'h00, dur_reg[`DUR_TO_LSB +: 5]} + 11'h001)
                         * 11'(`TIMEOUT_STEP_MS);
    assign timeout     = flash_on_reg & ms_tick & (to_ms_reg + 11'h001 >= to_limit);
    assign flash_end   = flash_on_reg & (timeout | ~flash_req);

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            flash_req_d_reg <= 1'h0;
            flash_on_reg    <= 1'h0;
            hwt_flash_reg   <= 1'h0;
            to_ms_reg       <= 11'h000;
        end else begin
            flash_req_d_reg <= flash_req;
            if (flash_start) begin
                flash_on_reg  <= 1'h1;
                hwt_flash_reg <= cfg1_reg[`CFG1_HWT_BIT];
                to_ms_reg     <= 11'h000;
            end else if (flash_end) begin
                flash_on_reg <= 1'h0;
            end else if (flash_on_reg && ms_tick) begin
                to_ms_reg <= to_ms_reg + 11'h001;
            end
        end
    end

    // ==========================================
    // Supply undervoltage monitor
    assign uv_low  = uv_s & mon_reg[`MON_UV_EN_BIT];
    // Counter saturates so one long dip trips once
    assign uv_trip = uv_low & (uv_cnt_reg == 16'(P_CYC_UV - 1));

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            uv_cnt_reg  <= 16'h0000;
            uv_act_reg  <= 1'h0;
            uv_seen_reg <= 1'h0;
        end else begin
            if (!uv_low) begin
                uv_cnt_reg <= 16'h0000;
            end else if (uv_cnt_reg != 16'(P_CYC_UV)) begin
                uv_cnt_reg <= uv_cnt_reg + 16'h0001;
            end
            if (uv_trip) begin
                uv_act_reg  <= 1'h1;
                uv_seen_reg <= 1'h0;
            end else if (uv_act_reg && uv_seen_reg && !uv_s) begin
                uv_act_reg  <= 1'h0;
                uv_seen_reg <= 1'h0;
            end else if (uv_act_reg && rd_flags) begin
                uv_seen_reg <= 1'h1;
            end
        end
    end

    // ==========================================
    // Ramp monitor, current limit and flags
    assign ramp_trip = mon_reg[`MON_RAMP_EN_BIT] & rlow_s & ramping_s & flash_on_reg;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ramp_hold_reg <= 1'h0;
            ilim_blk_reg  <= 1'h0;
            flags_reg     <= 8'h00;
        end else begin
            // Set wins over clear in both flops
            ramp_hold_reg <= ramp_trip | (ramp_hold_reg & ~rd_flags);
            ilim_blk_reg  <= limit_s | (ilim_blk_reg & ~cycle_s);
            // A read clears only the bits it returned; a flash start also clears bit 0
            flags_reg <= (flags_reg & ~(rd_flags ? rdata_reg : 8'h00))
                         & ~{7'h00, flash_start}
                         | {uv_trip, ramp_trip, 5'h00, timeout};
        end
    end

    // ==========================================
    // Drive level selection
    always_comb begin
        if (uv_act_reg && !cfg2_reg[`CFG2_UV_TORCH_BIT]) begin
            level_next = LVL_OFF;
        end else if (flash_on_reg) begin
            level_next = uv_act_reg ? LVL_TORCH : LVL_FLASH;
        end else if ((cfg1_reg[`CFG1_HWT_BIT] && mfi_s) || sw_mode == MODE_TORCH) begin
            level_next = LVL_TORCH;
        end else begin
            level_next = LVL_OFF;
        end
    end

    // ==========================================
    // Indicator
    assign ind_run = enable_reg[`EN_IND_BIT] & ~cfg1_reg[`CFG1_IND_SEL_BIT];

    indicator_blinker u_blinker (
        .i_sys_clk     (i_sys_clk),
        .i_nrst        (i_nrst),
        .i_ms_tick     (ms_tick),
        .i_run         (ind_run & enable_reg[`EN_BLINK_BIT]),
        .i_ramp_sel    (ind_reg[`IND_RAMP_LSB +: 2]),
        .i_pulse_code  (blink_reg[`BLK_PULSE_LSB +: 4]),
        .i_period_code (ind_reg[`IND_PERIOD_LSB +: 3]),
        .i_blank_code  (blink_reg[`BLK_BLANK_LSB +: 4]),
        .o_lit         (blink_lit),
        .o_phase       (phase_w)
    );

    // ==========================================
    // Registered outputs
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_first_current_source     <= 1'h0;
            o_second_current_source    <= 1'h0;
            o_drive_level              <= LVL_OFF;
            o_ramp_halt                <= 1'h0;
            o_limit_sel                <= 2'h0;
            o_switch_enable            <= 1'h0;
            o_supply_monitor_threshold <= 2'h0;
            o_ramp_monitor_threshold   <= 2'h0;
            o_indicator_on             <= 1'h0;
            o_indicator_current_level  <= 3'h0;
            o_indicator_phase          <= IND_RISE;
        end else begin
            o_drive_level           <= level_next;
            o_first_current_source  <= (level_next != LVL_OFF) & enable_reg[`EN_FIRST_BIT];
            o_second_current_source <= (level_next != LVL_OFF) & enable_reg[`EN_SECOND_BIT];
            o_ramp_halt             <= ramp_hold_reg;
            o_limit_sel             <= dur_reg[`DUR_ILIM_LSB +: 2];
            o_switch_enable         <= (level_next != LVL_OFF) & ~ilim_blk_reg & ~limit_s
                                       & ~ovp_s;
            o_supply_monitor_threshold <= mon_reg[`MON_UV_TH_LSB +: 2];
            o_ramp_monitor_threshold   <= mon_reg[`MON_RAMP_TH_LSB +: 2];
            o_indicator_on             <= ind_run & (~enable_reg[`EN_BLINK_BIT] | blink_lit);
            o_indicator_current_level  <= ind_reg[`IND_LEVEL_LSB +: 3];
            o_indicator_phase          <= phase_w;
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    chk_ramp_flag_set: assert property (ramp_trip |=> flags_reg[`FLG_RAMP_BIT])
        else $error("ramp flag not set");
    chk_ramp_hold_keep: assert property (ramp_hold_reg && !rd_flags |=> o_ramp_halt)
        else $error("ramp hold dropped before flag read");
    chk_source_gate: assert property (!enable_reg[`EN_FIRST_BIT] |=> !o_first_current_source)
        else $error("first source on while disabled");
    chk_hw_torch_on: assert property (cfg1_reg[`CFG1_HWT_BIT] && mfi_s && !flash_on_reg
        && !uv_act_reg |=> o_drive_level == LVL_TORCH)
        else $error("hardware torch not at torch level");
    chk_flash_wins: assert property (flash_on_reg && !uv_act_reg |=> o_drive_level == LVL_FLASH)
        else $error("flash did not override");
    chk_hwt_clear: assert property (flash_end && hwt_flash_reg && wr_idx != 4'h1
        |=> !cfg1_reg[`CFG1_HWT_BIT])
        else $error("hardware torch bit not cleared");
    chk_limit_block: assert property (limit_s |=> !o_switch_enable ##1 !o_switch_enable
        || cycle_s)
        else $error("switching during limited cycle");
    chk_timeout_end: assert property (timeout |=> !flash_on_reg && flags_reg[`FLG_TO_BIT])
        else $error("timeout did not end flash");
    chk_uv_deglitch: assert property ($rose(uv_act_reg) |-> $past(uv_low)
        && uv_cnt_reg == 16'(P_CYC_UV))
        else $error("undervoltage acted early");
    chk_uv_restore: assert property (uv_act_reg && uv_s |=> uv_act_reg)
        else $error("current restored while supply low");
endmodule

// file: include/flash_ctrl_consts.svh
`ifndef FLASH_CTRL_CONSTS_SVH
`define FLASH_CTRL_CONSTS_SVH
// ==========================================
// Timing
`define CLK_FREQ_HZ      25000000
`define CYC_PER_MS       (`CLK_FREQ_HZ / 1000)
`define UV_DEGLITCH_US   250
`define CYC_UV_DEGLITCH  ((`CLK_FREQ_HZ / 1000000) * `UV_DEGLITCH_US)
`define TIMEOUT_STEP_MS  32
`define PULSE_STEP_MS    32
`define RAMP_BASE_MS     78
// ==========================================
// Register byte offsets
`define OFS_ENABLE       5'h00
`define OFS_CFG1         5'h04
`define OFS_CFG2         5'h08
`define OFS_FLASH_DUR    5'h0C
`define OFS_INDICATOR    5'h10
`define OFS_BLINK        5'h14
`define OFS_SUPPLY_MON   5'h18
`define OFS_FLAGS        5'h1C
// ==========================================
// Field positions
`define EN_MODE_LSB      0
`define EN_FIRST_BIT     3
`define EN_SECOND_BIT    4
`define EN_IND_BIT       6
`define EN_BLINK_BIT     7
`define CFG1_IND_SEL_BIT 4
`define CFG1_HWT_BIT     7
`define CFG2_UV_TORCH_BIT 3
`define DUR_TO_LSB       0
`define DUR_ILIM_LSB     5
`define IND_LEVEL_LSB    0
`define IND_PERIOD_LSB   3
`define IND_RAMP_LSB     6
`define BLK_BLANK_LSB    0
`define BLK_PULSE_LSB    4
`define MON_UV_EN_BIT    0
`define MON_UV_TH_LSB    1
`define MON_RAMP_EN_BIT  3
`define MON_RAMP_TH_LSB  4
`define FLG_TO_BIT       0
`define FLG_RAMP_BIT     6
`define FLG_UV_BIT       7
// ==========================================
// Reset values
`define RST_ENABLE       8'h18
`define RST_CFG          8'h00
`define RST_FLASH_DUR    8'h0F
`endif

// file: include/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
    typedef enum logic [1:0] {LVL_OFF, LVL_TORCH, LVL_FLASH} drive_level_t;
    typedef enum logic [1:0] {MODE_OFF, MODE_PRIVACY, MODE_TORCH, MODE_FLASH} sw_mode_t;
    typedef enum logic [1:0] {IND_RISE, IND_HOLD_HI, IND_FALL, IND_HOLD_LO} ind_phase_t;
endpackage

// file: rtl/indicator_blinker.sv
`timescale 1ns/100ps
`include "flash_ctrl_consts.svh"
module indicator_blinker
    import flash_ctrl_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_ms_tick,
    input  wire logic        i_run,
    input  wire logic [1:0]  i_ramp_sel,
    input  wire logic [3:0]  i_pulse_code,
    input  wire logic [2:0]  i_period_code,
    input  wire logic [3:0]  i_blank_code,
    output logic             o_lit,
    output ind_phase_t       o_phase
);
    logic [9:0]  ramp_ms;
    logic [9:0]  pulse_ms;
    logic [9:0]  seg_len;
    logic [9:0]  cnt_reg;
    logic [7:0]  pcnt_reg;
    logic [7:0]  periods;
    logic [7:0]  total;
    logic        done;
    ind_phase_t  phase_reg;

    // ==========================================
    // Segment lengths
    assign ramp_ms  = 10'(`RAMP_BASE_MS) << i_ramp_sel;
    assign pulse_ms = 10'(i_pulse_code) * 10'(`PULSE_STEP_MS);
    assign seg_len  = (phase_reg == IND_RISE || phase_reg == IND_FALL) ? ramp_ms : pulse_ms;
    assign periods  = {5'h00, i_period_code} + 8'h01;
    // Blank spans blank_code further active times
    assign total    = periods * ({4'h0, i_blank_code} + 8'h01);
    // Zero-length hold is skipped without waiting for a tick
    assign done     = (seg_len == 10'h000) ||
                      (i_ms_tick && (cnt_reg + 10'h001 >= seg_len));

    // ==========================================
    // Period sequencer
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_reg   <= 10'h000;
            pcnt_reg  <= 8'h00;
            phase_reg <= IND_RISE;
        end else if (!i_run) begin
            cnt_reg   <= 10'h000;
            pcnt_reg  <= 8'h00;
            phase_reg <= IND_RISE;
        end else if (done) begin
            cnt_reg <= 10'h000;
            case (phase_reg)
                IND_RISE:    phase_reg <= IND_HOLD_HI;
                IND_HOLD_HI: phase_reg <= IND_FALL;
                IND_FALL:    phase_reg <= IND_HOLD_LO;
                default: begin
                    phase_reg <= IND_RISE;
                    pcnt_reg  <= (pcnt_reg + 8'h01 >= total) ? 8'h00 : pcnt_reg + 8'h01;
                end
            endcase
        end else if (i_ms_tick) begin
            cnt_reg <= cnt_reg + 10'h001;
        end
    end

    assign o_lit   = i_run && (pcnt_reg < periods);
    assign o_phase = phase_reg;
endmodule

// file: sim/analog_front_model.sv
`timescale 1ns/100ps
// ==========================================
// Switching-cycle clock of the boost stage
module analog_front_model (
    input  wire logic i_sys_clk,
    output logic      o_switch_cycle
);
    logic [1:0] phase_reg = 2'h0;
    // Short cycle keeps limit recovery quick in simulation
    always_ff @(posedge i_sys_clk) begin
        phase_reg <= phase_reg + 2'h1;
        o_switch_cycle <= (phase_reg == 2'h0);
    end
endmodule

// file: sim/flash_led_mode_control_tb.sv
`timescale 1ns/100ps
module flash_led_mode_control_tb
    import flash_ctrl_pkg::*;
;
    logic clk = 0, nrst = 0, rd = 0, wr = 0, trig = 0, mfi = 0, slo = 0, z = 0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic wt, s1, s2, swc;
    logic [1:0] sth;
    drive_level_t dl;
    logic [7:0] q;
    int num_errors = 0, check_count = 0, k;
    // ==========================================
    // Rows: register index, write data, read-back
    logic [20:0] rows [5] = '{21'h01_0808, 21'h03_0707, 21'h02_C5C5, 21'h06_0606,
                              21'h07_FF00};
    always #20 clk = ~clk;
    flash_led_mode_control #(.P_CYC_PER_MS(10), .P_CYC_UV(5)) dut_u (.i_sys_clk(clk),
        .i_nrst(nrst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wt), .i_flash_trigger(trig), .i_multi_function_input(mfi),
        .i_supply_low(slo), .i_ramp_supply_low(z), .i_flash_ramping(z), .i_limit_hit(z),
        .i_switch_cycle(swc), .i_overvoltage(z), .o_first_current_source(s1),
        .o_second_current_source(s2), .o_drive_level(dl), .o_ramp_halt(), .o_limit_sel(),
        .o_switch_enable(), .o_supply_monitor_threshold(sth), .o_ramp_monitor_threshold(),
        .o_indicator_on(), .o_indicator_current_level(), .o_indicator_phase());
    analog_front_model fe_u (.i_sys_clk(clk), .o_switch_cycle(swc));
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Waitrequest looked at mid-cycle, where it stands until the next rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        rd <= !w; wr <= w; addr <= a; wd <= {24'h000000, d};
        for (n = 0; n < 20; n++) begin
            @(negedge clk);
            if (wt === 1'b0) break;
        end
        if (n == 20) begin chk(8'h00, 8'hFF); give_verdict(); end
        @(posedge clk);
        q = rdat[7:0];
        rd <= 1'b0; wr <= 1'b0;
    endtask
    task automatic waitlvl(input drive_level_t e, input int lim);
        for (k = 0; k < lim && !(dl === e); k++) @(negedge clk);
        chk({6'h00, dl}, {6'h00, e});
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        bus(0, 5'h00, 8'h00); chk(q, 8'h18);
        bus(0, 5'h0C, 8'h00); chk(q, 8'h0F);
        foreach (rows[i]) begin
            bus(1, {rows[i][18:16], 2'h0}, rows[i][15:8]);
            bus(0, {rows[i][18:16], 2'h0}, 8'h00); chk(q, rows[i][7:0]);
        end
        chk({6'h00, sth}, 8'h03);
        $display("table done");
        bus(1, 5'h0C, 8'h00); bus(1, 5'h00, 8'h1B);
        waitlvl(LVL_FLASH, 10); chk({6'h00, s2, s1}, 8'h03);
        waitlvl(LVL_OFF, 400); chk(8'(k > 300), 8'h01);
        bus(0, 5'h1C, 8'h00); chk(q, 8'h01);
        bus(0, 5'h1C, 8'h00); chk(q, 8'h00);
        bus(0, 5'h00, 8'h00); chk(q, 8'h18);
        $display("timeout done");
        bus(1, 5'h0C, 8'h1F); bus(1, 5'h04, 8'h80); mfi <= 1'b1;
        waitlvl(LVL_TORCH, 10);
        trig <= 1'b1; waitlvl(LVL_FLASH, 10);
        trig <= 1'b0; waitlvl(LVL_OFF, 10);
        bus(0, 5'h04, 8'h00); chk(q, 8'h00);
        mfi <= 1'b0;
        $display("hw torch done");
        bus(1, 5'h18, 8'h01); bus(1, 5'h08, 8'h00); bus(1, 5'h00, 8'h1A);
        waitlvl(LVL_TORCH, 10);
        slo <= 1'b1; repeat (3) @(posedge clk); slo <= 1'b0; repeat (10) @(posedge clk);
        waitlvl(LVL_TORCH, 1);
        slo <= 1'b1; waitlvl(LVL_OFF, 20);
        bus(0, 5'h1C, 8'h00); chk(q, 8'h80);
        slo <= 1'b0; waitlvl(LVL_TORCH, 10);
        $display("undervoltage done");
        give_verdict();
    end
endmodule
